// ===== common/sbce_pkg.sv
// types of the dram command controller
package sbce_pkg;

  typedef enum logic [2:0] {
    SBCE_OP_NOP,
    SBCE_OP_MODE_LOAD,
    SBCE_OP_ACTIVATE,
    SBCE_OP_READ,
    SBCE_OP_WRITE,
    SBCE_OP_PRECHARGE
  } sbce_op_type;

  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       cke;
    logic [1:0] ba;
    logic [12:0] addr;
  } sbce_cmd_type;

  typedef struct packed {
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
    logic [1:0]  dm;
    logic        dqs_o;
    logic        dqs_oe;
  } sbce_wpin_type;

endpackage : sbce_pkg

// ===== common/sbce_regs.svh
// register offsets, field positions and timing counts of the dram command controller
`ifndef SBCE_REGS_SVH
`define SBCE_REGS_SVH

`define SBCE_OFS_CMD      8'h00
`define SBCE_OFS_ADDR     8'h04
`define SBCE_OFS_WDATA    8'h08
`define SBCE_OFS_STATUS   8'h0c
`define SBCE_OFS_RDATA    8'h10
`define SBCE_OFS_CFG      8'h14
`define SBCE_OFS_BANKS    8'h18

// command register fields
`define SBCE_CMD_OP_LSB   0
`define SBCE_CMD_OP_W     3
`define SBCE_CMD_A10_BIT  4
`define SBCE_CMD_BA_LSB   8
`define SBCE_CMD_MASK_LSB 12

// configuration register fields
`define SBCE_CFG_CL_LSB   0
`define SBCE_CFG_AL_LSB   4
`define SBCE_CFG_BL8_BIT  8
`define SBCE_CFG_RST      32'h0000_0003

// status bits
`define SBCE_ST_BUSY      0
`define SBCE_ST_RVALID    1
`define SBCE_ST_ERR       2

// timing in picoseconds, clock period 8000 ps
`define SBCE_TCK_PS       8000
`define SBCE_TMRD_PS      16000
`define SBCE_TRCD_PS      15000
`define SBCE_TRP_PS       15000
`define SBCE_TRPA_PS      17500
`define SBCE_TRC_PS       55000
`define SBCE_TRRD_PS      7500
`define SBCE_TWR_PS       15000
`define SBCE_TWTR_PS      7500
`define SBCE_CYC(ps)      (((ps) + `SBCE_TCK_PS - 1) / `SBCE_TCK_PS)
`define SBCE_WTR_MIN      2

// link clock divider: half period in system clocks
`define SBCE_CK_HALF      5

`endif

// ===== hw/sbce_ahb_slave.sv
// ahb-lite slave holding the controller's own registers
`timescale 1ns/100ps
`default_nettype none
`include "sbce_regs.svh"

module sbce_ahb_slave (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] status,
  input  wire logic [31:0] rdata,
  input  wire logic [3:0]  banks,
  output logic      [31:0] cmd_q,
  output logic      [31:0] addr_q,
  output logic      [31:0] wdata_q,
  output logic      [31:0] cfg_q,
  output logic             go_q
);

  logic       wr_q;
  logic [7:0] wa_q;
  logic       sel;

  assign sel       = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_q   <= 1'b0;
      wa_q   <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_q <= sel && hwrite;
      wa_q <= haddr[7:0];
      if (sel && !hwrite) begin
        case (haddr[7:0])
          `SBCE_OFS_CMD:    hrdata <= cmd_q;
          `SBCE_OFS_ADDR:   hrdata <= addr_q;
          `SBCE_OFS_WDATA:  hrdata <= wdata_q;
          `SBCE_OFS_STATUS: hrdata <= status;
          `SBCE_OFS_RDATA:  hrdata <= rdata;
          `SBCE_OFS_CFG:    hrdata <= cfg_q;
          `SBCE_OFS_BANKS:  hrdata <= {28'h0, banks};
          default:          hrdata <= 32'h0;
        endcase
      end
    end
  end

  // writing the command register launches it
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_q   <= 32'h0;
      addr_q  <= 32'h0;
      wdata_q <= 32'h0;
      cfg_q   <= `SBCE_CFG_RST;
      go_q    <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (wr_q) begin
        case (wa_q)
          `SBCE_OFS_CMD: begin
            cmd_q <= hwdata;
            go_q  <= 1'b1;
          end
          `SBCE_OFS_ADDR:  addr_q  <= hwdata;
          `SBCE_OFS_WDATA: wdata_q <= hwdata;
          `SBCE_OFS_CFG:   cfg_q   <= hwdata;
          default: ;
        endcase
      end
    end
  end

endmodule : sbce_ahb_slave

`default_nettype wire

// ===== hw/sbce_ck_gen.sv
// divides the system clock into the link clock and flags its rising and falling edges
`timescale 1ns/100ps
`default_nettype none
`include "sbce_regs.svh"

module sbce_ck_gen (
  input  wire logic clock,
  input  wire logic reset,
  output logic      ck_q,
  output logic      rise_q,
  output logic      fall_q
);

  logic [3:0] cnt_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q  <= 4'h0;
      ck_q   <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (cnt_q == 4'(`SBCE_CK_HALF - 1)) begin
        cnt_q  <= 4'h0;
        ck_q   <= ~ck_q;
        rise_q <= ~ck_q;
        fall_q <= ck_q;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

endmodule : sbce_ck_gen

`default_nettype wire

// ===== hw/sbce_host.sv
// host controller issuing dram commands from software orders
`timescale 1ns/100ps
`default_nettype none
`include "sbce_regs.svh"

module sbce_host (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             ck_q,
  output logic             ck_n_q,
  output logic             cke_q,
  output logic             cs_n_q,
  output logic             ras_n_q,
  output logic             cas_n_q,
  output logic             we_n_q,
  output logic      [1:0]  ba_q,
  output logic      [12:0] a_q,
  output logic      [15:0] dq_o_q,
  output logic      [15:0] dq_oe_q,
  input  wire logic [15:0] dq_i,
  output logic      [1:0]  dm_q,
  output logic             dqs_o_q,
  output logic             dqs_n_o_q,
  output logic             dqs_oe_q,
  input  wire logic        dqs_i
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_WAIT, ST_WDATA, ST_RDATA
  } sbce_st_type;

  logic [31:0] cmd_r, addr_r, wdata_r, cfg_r, rdata_q, status;
  logic        go, ck_int, rise, fall;
  sbce_st_type st_q;
  sbce_pkg::sbce_op_type op;
  logic [1:0]  cba;
  logic        a10;
  logic [3:0]  open_q;
  logic [12:0] row_q [4];
  logic [7:0]  act_age_q [4];
  logic [7:0]  pre_age_q [4];
  logic [7:0]  pre_need_q [4];
  logic [7:0]  wr_age_q [4];
  logic [7:0]  any_act_age_q, mrd_age_q, wend_age_q, since_q;
  logic [4:0]  lat_cnt_q;
  logic [3:0]  beat_q;
  logic        err_q, rvalid_q, wact_q;
  logic [1:0]  dq_s1_q, dq_s2_q;
  logic [15:0] dqi_s1_q, dqi_s2_q;
  logic [3:0]  cl, al, rl, bl;

  assign op  = sbce_pkg::sbce_op_type'(cmd_r[`SBCE_CMD_OP_LSB +: `SBCE_CMD_OP_W]);
  assign cba = cmd_r[`SBCE_CMD_BA_LSB +: 2];
  assign a10 = cmd_r[`SBCE_CMD_A10_BIT];
  assign cl  = cfg_r[`SBCE_CFG_CL_LSB +: 4];
  assign al  = cfg_r[`SBCE_CFG_AL_LSB +: 4];
  assign rl  = al + cl;
  assign bl  = cfg_r[`SBCE_CFG_BL8_BIT] ? 4'h8 : 4'h4;
  assign status = {29'h0, err_q, rvalid_q, st_q != ST_IDLE || go};

  sbce_ahb_slave u_bus (
    .clock     (clock),
    .reset     (reset),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .status    (status),
    .rdata     (rdata_q),
    .banks     (open_q),
    .cmd_q     (cmd_r),
    .addr_q    (addr_r),
    .wdata_q   (wdata_r),
    .cfg_q     (cfg_r),
    .go_q      (go)
  );

  sbce_ck_gen u_ck (
    .clock  (clock),
    .reset  (reset),
    .ck_q   (ck_int),
    .rise_q (rise),
    .fall_q (fall)
  );

  // whole link cycles needed before this command is legal
  function automatic logic ready_to_issue(input sbce_pkg::sbce_op_type o, input logic [1:0] b,
                                          input logic all);
    logic ok;
    ok = mrd_age_q >= 8'(`SBCE_CYC(`SBCE_TMRD_PS));
    case (o)
      sbce_pkg::SBCE_OP_MODE_LOAD: ok = ok && (open_q == 4'h0) && pre_done_all();
      sbce_pkg::SBCE_OP_ACTIVATE:
        ok = ok && !open_q[b] && act_age_q[b] >= 8'(`SBCE_CYC(`SBCE_TRC_PS))
             && any_act_age_q >= 8'(`SBCE_CYC(`SBCE_TRRD_PS))
             && pre_age_q[b] >= pre_need_q[b];
      sbce_pkg::SBCE_OP_READ:
        ok = ok && open_q[b] && act_age_q[b] >= 8'(`SBCE_CYC(`SBCE_TRCD_PS))
             && wend_age_q >= 8'(`SBCE_CYC(`SBCE_TWTR_PS))
             && wend_age_q >= 8'(`SBCE_WTR_MIN);
      sbce_pkg::SBCE_OP_WRITE:
        ok = ok && open_q[b] && act_age_q[b] >= 8'(`SBCE_CYC(`SBCE_TRCD_PS));
      sbce_pkg::SBCE_OP_PRECHARGE:
        ok = ok && (all ? wr_done_all() : wr_age_q[b] >= 8'(`SBCE_CYC(`SBCE_TWR_PS)));
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : ready_to_issue

  function automatic logic pre_done_all();
    logic r;
    r = 1'b1;
    for (int i = 0; i < 4; i++) r = r && pre_age_q[i] >= pre_need_q[i];
    return r;
  endfunction : pre_done_all

  function automatic logic wr_done_all();
    logic r;
    r = 1'b1;
    for (int i = 0; i < 4; i++) r = r && wr_age_q[i] >= 8'(`SBCE_CYC(`SBCE_TWR_PS));
    return r;
  endfunction : wr_done_all

  logic issue;
  assign issue = (st_q == ST_ISSUE) && fall && ready_to_issue(op, cba, a10);

  // sequencer
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q      <= ST_IDLE;
      lat_cnt_q <= 5'h00;
      beat_q    <= 4'h0;
      err_q     <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: if (go) begin
          st_q  <= ST_ISSUE;
          err_q <= 1'b0;
        end
        ST_ISSUE: if (issue) begin
          lat_cnt_q <= (op == sbce_pkg::SBCE_OP_WRITE) ? {rl - 4'h1, 1'b0} : {rl, 1'b1};
          beat_q    <= 4'h0;
          case (op)
            sbce_pkg::SBCE_OP_READ:  st_q <= ST_WAIT;
            sbce_pkg::SBCE_OP_WRITE: st_q <= ST_WAIT;
            default:                 st_q <= ST_IDLE;
          endcase
        end
        // latency counted in half link cycles
        ST_WAIT: if (rise || fall) begin
          if (lat_cnt_q <= 5'h01)
            st_q <= (op == sbce_pkg::SBCE_OP_WRITE) ? ST_WDATA : ST_RDATA;
          lat_cnt_q <= lat_cnt_q - 5'h01;
        end
        ST_WDATA, ST_RDATA: if (rise || fall) begin
          beat_q <= beat_q + 4'h1;
          if (beat_q == bl - 4'h1) st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // command pins change at falling ck so the device samples them mid-cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      cke_q <= 1'b0;
      {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'b1111;
      ba_q  <= 2'b00;
      a_q   <= 13'h0;
    end else if (fall) begin
      cke_q <= 1'b1;
      {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'b0111;
      if (issue) begin
        ba_q <= cba;
        a_q  <= addr_r[12:0];
        case (op)
          sbce_pkg::SBCE_OP_MODE_LOAD: {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'b0000;
          sbce_pkg::SBCE_OP_ACTIVATE:  {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'b0011;
          sbce_pkg::SBCE_OP_READ: begin
            {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'b0101;
            a_q[10] <= a10;
          end
          sbce_pkg::SBCE_OP_WRITE: begin
            {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'b0100;
            a_q[10] <= a10;
          end
          sbce_pkg::SBCE_OP_PRECHARGE: begin
            {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'b0010;
            a_q[10] <= a10;
          end
          default: ;
        endcase
      end
    end
  end

  // per-bank row state, per-bank and shared timers, counted in link cycles
  always_ff @(posedge clock) begin
    if (reset) begin
      open_q        <= 4'h0;
      any_act_age_q <= 8'hff;
      mrd_age_q     <= 8'hff;
      wend_age_q    <= 8'hff;
      for (int i = 0; i < 4; i++) begin
        row_q[i]      <= 13'h0;
        act_age_q[i]  <= 8'hff;
        pre_age_q[i]  <= 8'hff;
        pre_need_q[i] <= 8'h00;
        wr_age_q[i]   <= 8'hff;
      end
    end else if (issue) begin
      case (op)
        sbce_pkg::SBCE_OP_MODE_LOAD: mrd_age_q <= 8'h0;
        sbce_pkg::SBCE_OP_ACTIVATE: begin
          open_q[cba]    <= 1'b1;
          row_q[cba]     <= addr_r[12:0];
          act_age_q[cba] <= 8'h0;
          any_act_age_q  <= 8'h0;
        end
        sbce_pkg::SBCE_OP_PRECHARGE: begin
          for (int i = 0; i < 4; i++) begin
            if (a10 || cba == 2'(i)) begin
              open_q[i]     <= 1'b0;
              pre_age_q[i]  <= 8'h0;
              pre_need_q[i] <= a10 ? 8'(`SBCE_CYC(`SBCE_TRPA_PS))
                                   : 8'(`SBCE_CYC(`SBCE_TRP_PS));
            end
          end
        end
        sbce_pkg::SBCE_OP_READ, sbce_pkg::SBCE_OP_WRITE:
          if (a10) open_q[cba] <= 1'b0;
        default: ;
      endcase
    end else if (rise) begin
      any_act_age_q <= (any_act_age_q == 8'hff) ? 8'hff : any_act_age_q + 8'h1;
      mrd_age_q     <= (mrd_age_q == 8'hff) ? 8'hff : mrd_age_q + 8'h1;
      wend_age_q    <= (st_q == ST_WDATA) ? 8'h0 :
                       (wend_age_q == 8'hff) ? 8'hff : wend_age_q + 8'h1;
      for (int i = 0; i < 4; i++) begin
        act_age_q[i] <= (act_age_q[i] == 8'hff) ? 8'hff : act_age_q[i] + 8'h1;
        pre_age_q[i] <= (pre_age_q[i] == 8'hff) ? 8'hff : pre_age_q[i] + 8'h1;
        wr_age_q[i]  <= (st_q == ST_WDATA && ba_q == 2'(i)) ? 8'h0 :
                        (wr_age_q[i] == 8'hff) ? 8'hff : wr_age_q[i] + 8'h1;
      end
    end
  end

  // write strobe, data and mask; read data capture
  always_ff @(posedge clock) begin
    if (reset) begin
      dqs_o_q   <= 1'b0;
      dqs_n_o_q <= 1'b1;
      dqs_oe_q  <= 1'b0;
      dq_o_q    <= 16'h0;
      dq_oe_q   <= 16'h0;
      dm_q      <= 2'b11;
      rdata_q   <= 32'h0;
      rvalid_q  <= 1'b0;
      wact_q    <= 1'b0;
      dq_s1_q   <= 2'b00;
      dq_s2_q   <= 2'b00;
      dqi_s1_q  <= 16'h0;
      dqi_s2_q  <= 16'h0;
    end else begin
      dq_s1_q  <= {dqs_i, 1'b0};
      dq_s2_q  <= dq_s1_q;
      dqi_s1_q <= dq_i;
      dqi_s2_q <= dqi_s1_q;
      if (go) rvalid_q <= 1'b0;
      if (st_q == ST_WAIT && op == sbce_pkg::SBCE_OP_WRITE && lat_cnt_q <= 5'h02) begin
        dqs_oe_q  <= 1'b1;
        dqs_o_q   <= 1'b0;
        dqs_n_o_q <= 1'b1;
      end
      if (st_q == ST_WDATA && (rise || fall)) begin
        dqs_o_q   <= ~beat_q[0];
        dqs_n_o_q <= beat_q[0];
        dq_oe_q   <= 16'hffff;
        dq_o_q    <= beat_q[0] ? wdata_r[31:16] : wdata_r[15:0];
        dm_q      <= beat_q[0] ? cmd_r[`SBCE_CMD_MASK_LSB + 2 +: 2]
                               : cmd_r[`SBCE_CMD_MASK_LSB +: 2];
        wact_q    <= 1'b1;
      end else if (wact_q && st_q != ST_WDATA && (rise || fall)) begin
        dqs_o_q   <= 1'b0;
        dqs_n_o_q <= 1'b1;
        dq_oe_q   <= 16'h0;
        dm_q      <= 2'b11;
        wact_q    <= 1'b0;
      end else if (!wact_q && st_q != ST_WAIT && st_q != ST_WDATA) begin
        dqs_oe_q <= 1'b0;
      end
      if (st_q == ST_RDATA && (rise || fall) && beat_q < 4'h2) begin
        if (beat_q[0]) rdata_q[31:16] <= dqi_s2_q;
        else           rdata_q[15:0]  <= dqi_s2_q;
        if (beat_q[0]) rvalid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ck_q   <= 1'b0;
      ck_n_q <= 1'b1;
    end else begin
      ck_q   <= ck_int;
      ck_n_q <= ~ck_int;
    end
  end

endmodule : sbce_host

`default_nettype wire

// ===== testbench/sbce_dram_model.sv
// behavioural dram device facing the controller pins
`timescale 1ns/100ps
`default_nettype none

module sbce_dram_model #(
  parameter int  RL     = 3,
  parameter int  BL     = 4,
  parameter real TCK_NS = 80.0
) (
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  ba,
  input  wire logic [12:0] a,
  input  wire logic [15:0] dq_o,
  input  wire logic [15:0] dq_oe,
  input  wire logic [1:0]  dm,
  input  wire logic        dqs_o,
  input  wire logic        dqs_oe,
  output logic      [15:0] dq_i,
  output logic             dqs_i,
  output logic      [7:0]  err_q
);
  logic [15:0] mem [0:4095];
  logic [3:0]  open_q = 4'h0;
  logic        drv = 1'b0;
  logic        sdqs = 1'b0;
  logic [15:0] sdq = 16'h0;
  logic [15:0] junk = 16'h5a3c;
  initial err_q = 8'h0;
  // released lines never keep their last value
  always @(posedge ck) junk <= ~junk;
  assign dq_i  = drv ? sdq : (dq_oe != 16'h0 ? dq_o : junk);
  assign dqs_i = drv ? sdqs : (dqs_oe ? dqs_o : junk[0]);
  task automatic rd_burst(input logic [1:0] b, input logic [9:0] c, input logic ap);
    repeat (RL - 1) @(posedge ck);
    drv = 1'b1;
    sdqs = 1'b0;
    @(posedge ck);
    for (int i = 0; i < BL; i++) begin
      sdq = mem[{b, c[9:2], 2'(c[1:0] + 2'(i))}];
      sdqs = ~i[0];
      if (i[0]) @(posedge ck);
      else @(negedge ck);
    end
    drv = 1'b0;
    if (ap) open_q[b] = 1'b0;
  endtask : rd_burst
  task automatic wr_burst(input logic [1:0] b, input logic [9:0] c, input logic ap);
    realtime     t0;
    logic [11:0] ix;
    t0 = $realtime;
    @(posedge dqs_o iff dqs_oe);
    if ($realtime - t0 > (RL - 1) * TCK_NS + 20.0 || $realtime - t0 < (RL - 1) * TCK_NS - 20.0)
      err_q = err_q + 8'h1;
    for (int i = 0; i < BL; i++) begin
      if (i[0]) @(negedge dqs_o);
      else if (i > 0) @(posedge dqs_o);
      #0.1;
      ix = {b, c[9:2], 2'(c[1:0] + 2'(i))};
      if (!dm[0]) mem[ix][7:0] = dq_o[7:0];
      if (!dm[1]) mem[ix][15:8] = dq_o[15:8];
    end
    if (ap) open_q[b] = 1'b0;
  endtask : wr_burst
  always @(posedge ck) begin
    if (!cs_n && cke) begin
      case ({ras_n, cas_n, we_n})
        3'b000: if (open_q != 4'h0) err_q = err_q + 8'h1;
        3'b011: begin
          if (open_q[ba]) err_q = err_q + 8'h1;
          open_q[ba] = 1'b1;
        end
        3'b101: begin
          if (!open_q[ba]) err_q = err_q + 8'h1;
          fork rd_burst(ba, a[9:0], a[10]); join_none
        end
        3'b100: begin
          if (!open_q[ba]) err_q = err_q + 8'h1;
          fork wr_burst(ba, a[9:0], a[10]); join_none
        end
        3'b010: if (a[10]) open_q = 4'h0;
        else open_q[ba] = 1'b0;
        default: ;
      endcase
    end
  end
endmodule : sbce_dram_model
`default_nettype wire

// ===== testbench/sbce_host_asserts.sv
// pin-level assertions of the dram command controller
`timescale 1ns/100ps
`default_nettype none
`include "sbce_regs.svh"

module sbce_host_asserts (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        ck_q,
  input wire logic        ck_n_q,
  input wire logic        cke_q,
  input wire logic        cs_n_q,
  input wire logic        ras_n_q,
  input wire logic        cas_n_q,
  input wire logic        we_n_q,
  input wire logic [1:0]  ba_q,
  input wire logic [12:0] a_q,
  input wire logic [15:0] dq_oe_q,
  input wire logic        dqs_o_q,
  input wire logic        dqs_n_o_q,
  input wire logic        dqs_oe_q
);
  localparam int TRC_CYC = `SBCE_CYC(`SBCE_TRC_PS);
  localparam int WTR_CYC = 10;
  logic       ck_d_q;
  logic [3:0] open_q;
  logic [7:0] act_age_q;
  logic [7:0] wr_age_q;
  logic       live;
  logic [2:0] cmd;
  // command as the device samples it at the link clock rise
  assign live = ck_q && !ck_d_q && !cs_n_q && cke_q;
  assign cmd  = {ras_n_q, cas_n_q, we_n_q};
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  always_ff @(posedge clock) begin
    ck_d_q <= reset ? 1'b0 : ck_q;
  end
  // auto-precharge counts as closing at the command
  always_ff @(posedge clock) begin
    if (reset) open_q <= 4'h0;
    else if (live && cmd == 3'b011) open_q[ba_q] <= 1'b1;
    else if (live && cmd == 3'b010 && a_q[10]) open_q <= 4'h0;
    else if (live && (cmd == 3'b010 || (cmd[2:1] == 2'b10 && a_q[10]))) open_q[ba_q] <= 1'b0;
  end
  always_ff @(posedge clock) begin
    if (reset || (live && cmd == 3'b011)) act_age_q <= reset ? 8'hff : 8'h0;
    else if (act_age_q != 8'hff) act_age_q <= act_age_q + 8'h1;
  end
  always_ff @(posedge clock) begin
    if (reset) wr_age_q <= 8'hff;
    else if (dqs_oe_q) wr_age_q <= 8'h0;
    else if (wr_age_q != 8'hff) wr_age_q <= wr_age_q + 8'h1;
  end
  property p_ck_pair; ck_n_q != ck_q; endproperty
  a_ck_pair: assert property (p_ck_pair) else $error("link clock pair not complementary");
  property p_ck_period; $rose(ck_q) |-> ck_q[*5] ##1 !ck_q[*5] ##1 ck_q; endproperty
  a_ck_period: assert property (p_ck_period) else $error("link clock period wrong");
  property p_cmd_at_low;
    $changed({cs_n_q, ras_n_q, cas_n_q, we_n_q, ba_q, a_q}) |-> !ck_q;
  endproperty
  a_cmd_at_low: assert property (p_cmd_at_low) else $error("command moved near clock rise");
  property p_cmd_hold;
    live && cmd != 3'b111 |-> $stable({ras_n_q, cas_n_q, we_n_q, ba_q, a_q})[*4];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command not held around rise");
  property p_lm_idle; live && cmd == 3'b000 |-> open_q == 4'h0; endproperty
  a_lm_idle: assert property (p_lm_idle) else $error("mode load with open bank");
  property p_act_closed;
    live && cmd == 3'b011 |-> !open_q[ba_q] && act_age_q >= TRC_CYC;
  endproperty
  a_act_closed: assert property (p_act_closed) else $error("activate to open bank");
  property p_rw_open; live && cmd[2:1] == 2'b10 |-> open_q[ba_q]; endproperty
  a_rw_open: assert property (p_rw_open) else $error("access to closed bank");
  property p_rd_after_wr; live && cmd == 3'b101 |-> wr_age_q >= WTR_CYC; endproperty
  a_rd_after_wr: assert property (p_rd_after_wr) else $error("read too soon after write");
  property p_dqs_comp; dqs_oe_q |-> dqs_n_o_q != dqs_o_q; endproperty
  a_dqs_comp: assert property (p_dqs_comp) else $error("strobe pair not complementary");
  property p_dqs_pre; $rose(dqs_oe_q) |-> !dqs_o_q ##1 !dqs_o_q; endproperty
  a_dqs_pre: assert property (p_dqs_pre) else $error("write preamble not low");
  property p_dq_window; dq_oe_q != 16'h0 |-> dqs_oe_q; endproperty
  a_dq_window: assert property (p_dq_window) else $error("data driven without strobe");
endmodule : sbce_host_asserts
`default_nettype wire

// ===== testbench/sbce_host_bench.sv
// testbench of the dram command controller
`timescale 1ns/100ps
`default_nettype none
`include "sbce_regs.svh"

module sbce_host_bench;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, ck_q, ck_n_q, cke_q, cs_n_q, ras_n_q, cas_n_q, we_n_q;
  logic [1:0]  ba_q, dm_q;
  logic [12:0] a_q;
  logic [15:0] dq_o_q, dq_oe_q, dq_i;
  logic        dqs_o_q, dqs_n_o_q, dqs_oe_q, dqs_i;
  logic [7:0]  model_err;
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #4 clock = ~clock;

  sbce_host dut_u (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ck_q(ck_q), .ck_n_q(ck_n_q), .cke_q(cke_q),
    .cs_n_q(cs_n_q), .ras_n_q(ras_n_q), .cas_n_q(cas_n_q), .we_n_q(we_n_q), .ba_q(ba_q),
    .a_q(a_q), .dq_o_q(dq_o_q), .dq_oe_q(dq_oe_q), .dq_i(dq_i), .dm_q(dm_q), .dqs_o_q(dqs_o_q),
    .dqs_n_o_q(dqs_n_o_q), .dqs_oe_q(dqs_oe_q), .dqs_i(dqs_i));

  sbce_dram_model mem_u (.ck(ck_q), .cke(cke_q), .cs_n(cs_n_q), .ras_n(ras_n_q),
    .cas_n(cas_n_q), .we_n(we_n_q), .ba(ba_q), .a(a_q), .dq_o(dq_o_q), .dq_oe(dq_oe_q),
    .dm(dm_q), .dqs_o(dqs_o_q), .dqs_oe(dqs_oe_q), .dq_i(dq_i), .dqs_i(dqs_i),
    .err_q(model_err));

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one ahb-lite single word transfer, waits on hready
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rdv = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, ofs, d, x);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, ofs, 32'h0, x);
    check(what, x, exp);
  endtask : rdc

  task automatic op(input sbce_pkg::sbce_op_type code, input logic a10, input logic [1:0] b,
                    input logic [3:0] mask, input logic [12:0] adr);
    logic [31:0] x;
    int          n;
    wr(`SBCE_OFS_ADDR, {19'h0, adr});
    wr(`SBCE_OFS_CMD, {16'h0, mask, 2'h0, b, 3'h0, a10, 1'b0, code});
    n = 0;
    x = 32'h1;
    while (x[0] !== 1'b0 && n < 400) begin
      ahb(1'b0, `SBCE_OFS_STATUS, 32'h0, x);
      n++;
    end
    check("busy", {31'h0, x[0]}, 32'h0);
  endtask : op

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rdc("cfg", `SBCE_OFS_CFG, `SBCE_CFG_RST);
    rdc("banks", `SBCE_OFS_BANKS, 32'h0);
    rdc("status", `SBCE_OFS_STATUS, 32'h0);
    wr(8'h1c, 32'hffff_ffff);
    rdc("unmapped", 8'h1c, 32'h0);
    op(sbce_pkg::SBCE_OP_NOP, 1'b0, 2'h0, 4'h0, 13'h0);
    op(sbce_pkg::SBCE_OP_MODE_LOAD, 1'b0, 2'h0, 4'h0, 13'h0032);
    op(sbce_pkg::SBCE_OP_ACTIVATE, 1'b0, 2'h1, 4'h0, 13'h0123);
    op(sbce_pkg::SBCE_OP_ACTIVATE, 1'b0, 2'h2, 4'h0, 13'h0456);
    rdc("banks", `SBCE_OFS_BANKS, 32'h6);
    wr(`SBCE_OFS_WDATA, 32'ha5a5_5a5a);
    op(sbce_pkg::SBCE_OP_WRITE, 1'b0, 2'h1, 4'h0, 13'h0008);
    op(sbce_pkg::SBCE_OP_READ, 1'b0, 2'h1, 4'h0, 13'h0008);
    rdc("rdata", `SBCE_OFS_RDATA, 32'ha5a5_5a5a);
    wr(`SBCE_OFS_WDATA, 32'h1111_2222);
    op(sbce_pkg::SBCE_OP_WRITE, 1'b0, 2'h1, 4'b1001, 13'h0008);
    op(sbce_pkg::SBCE_OP_READ, 1'b1, 2'h1, 4'h0, 13'h0008);
    rdc("rdata", `SBCE_OFS_RDATA, 32'ha511_225a);
    rdc("banks", `SBCE_OFS_BANKS, 32'h4);
    wr(`SBCE_OFS_WDATA, 32'h0f0f_f0f0);
    op(sbce_pkg::SBCE_OP_WRITE, 1'b1, 2'h2, 4'h0, 13'h0010);
    rdc("banks", `SBCE_OFS_BANKS, 32'h0);
    op(sbce_pkg::SBCE_OP_ACTIVATE, 1'b0, 2'h0, 4'h0, 13'h0040);
    op(sbce_pkg::SBCE_OP_ACTIVATE, 1'b0, 2'h3, 4'h0, 13'h0041);
    op(sbce_pkg::SBCE_OP_PRECHARGE, 1'b0, 2'h0, 4'h0, 13'h0);
    rdc("banks", `SBCE_OFS_BANKS, 32'h8);
    op(sbce_pkg::SBCE_OP_PRECHARGE, 1'b0, 2'h0, 4'h0, 13'h0);
    rdc("status", `SBCE_OFS_STATUS, 32'h0);
    op(sbce_pkg::SBCE_OP_PRECHARGE, 1'b1, 2'h0, 4'h0, 13'h0);
    rdc("banks", `SBCE_OFS_BANKS, 32'h0);
    check("model", {24'h0, model_err}, 32'h0);
    end_of_test();
  end
endmodule : sbce_host_bench

bind sbce_host sbce_host_asserts chk_u (.clock(clock), .reset(reset), .ck_q(ck_q),
  .ck_n_q(ck_n_q), .cke_q(cke_q), .cs_n_q(cs_n_q), .ras_n_q(ras_n_q), .cas_n_q(cas_n_q),
  .we_n_q(we_n_q), .ba_q(ba_q), .a_q(a_q), .dq_oe_q(dq_oe_q), .dqs_o_q(dqs_o_q),
  .dqs_n_o_q(dqs_n_o_q), .dqs_oe_q(dqs_oe_q));
`default_nettype wire
